// File: can_tx_history_buffer_tb_top.sv
// testbench joining both ends with a queue model of the buffer
`timescale 1ns/10ps
module can_tx_history_buffer_tb_top;
    logic sys_clk = 0, rst = 1, hist_buffer_enable = 0, hist_irq_mode_sel = 1;
    logic hist_irq_enable = 1, hist_overflow_irq_enable = 1, hist_irq_flag_clr = 0;
    logic hist_overflow_flag_clr = 0, hist_pointer_wr = 0, done_req = 0, done_keep = 0;
    logic [2:0] hist_log_kinds = 3'h7;
    logic [7:0] hist_pointer_control = 8'h00;
    logic [1:0] done_src = 2'h0;
    logic [3:0] done_buf_index = 4'h0, done_fifo_link = 4'h0, done_queue_index = 4'h0;
    logic [3:0] irq_sources = 4'h0;
    logic [15:0] done_label = 16'h0000, done_tstamp = 16'h0000;
    logic hist_irq_flag, hist_overflow_flag, hist_empty_flag, channel_tx_interrupt;
    logic global_error_irq, hist_full_flag;
    logic [4:0] hist_count, global_tx_irq_status;
    cth_pkg::cth_rec_type hist_access_window;
    logic [38:0] mq[$];
    int err_count = 0, n_tests = 0;
    cth_if link_if();
    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;
    cth_tx_source u_cth_tx_source (.sys_clk, .rst, .link(link_if.host), .done_req, .done_src,
        .done_buf_index, .done_fifo_link, .done_queue_index, .done_keep, .done_label,
        .done_tstamp, .irq_sources);
    cth_history #(.DEPTH(16), .IRQ_LEVEL(6)) u_cth_history (.sys_clk, .rst,
        .link(link_if.device), .hist_buffer_enable, .hist_irq_mode_sel, .hist_irq_enable,
        .hist_log_kinds, .hist_overflow_irq_enable, .hist_irq_flag_clr, .hist_overflow_flag_clr,
        .hist_pointer_wr, .hist_pointer_control, .hist_irq_flag, .hist_overflow_flag,
        .hist_empty_flag, .hist_full_flag, .hist_count, .hist_access_window,
        .global_tx_irq_status, .channel_tx_interrupt, .global_error_irq);
    cth_history_asserts #(.DEPTH(16), .IRQ_LEVEL(6)) u_chk (.sys_clk, .rst,
        .tx_done(link_if.tx_done), .tx_src(link_if.tx_src), .tx_hist_keep(link_if.tx_hist_keep),
        .hist_buffer_enable, .hist_irq_mode_sel, .hist_irq_enable, .hist_log_kinds,
        .hist_overflow_irq_enable, .hist_irq_flag_clr, .hist_overflow_flag_clr, .hist_pointer_wr,
        .hist_irq_flag, .hist_overflow_flag, .hist_empty_flag, .hist_count,
        .global_tx_irq_status, .global_error_irq);
    // compare one result and count it
    task automatic chk(input string n, input logic [38:0] e, input logic [38:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // wait edges, then step past them
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // one completion event; the model logs it when marked and selected
    task automatic store(input int s, input logic k);
        logic [3:0] b, f, q;
        logic [31:0] lt;
        b = 4'($urandom);
        f = 4'($urandom);
        q = 4'($urandom);
        lt = $urandom;
        @(posedge sys_clk);
        if (k && hist_buffer_enable && hist_log_kinds[s] && mq.size() < 16)
            mq.push_back({3'b001 << s, s == 0 ? b : s == 1 ? f : q, lt});
        done_req <= 1'b1;
        done_src <= 2'(s);
        done_keep <= k;
        done_buf_index <= b;
        done_fifo_link <= f;
        done_queue_index <= q;
        {done_label, done_tstamp} <= lt;
        @(posedge sys_clk);
        done_req <= 1'b0;
        tick(2);
    endtask
    // pointer control write, window checked before and count after
    task automatic pop(input logic [7:0] c);
        if (mq.size() > 0)
            chk("window", mq[0], hist_access_window);
        @(posedge sys_clk);
        if (c == 8'hFF && hist_buffer_enable && mq.size() > 0)
            void'(mq.pop_front());
        hist_pointer_wr <= 1'b1;
        hist_pointer_control <= c;
        @(posedge sys_clk);
        hist_pointer_wr <= 1'b0;
        tick(1);
        chk("count", 39'(mq.size()), 39'(hist_count));
    endtask
    // one-cycle clear pulse of the overflow or the interrupt flag
    task automatic clr(input bit o);
        @(posedge sys_clk);
        hist_overflow_flag_clr <= o;
        hist_irq_flag_clr <= !o;
        @(posedge sys_clk);
        hist_overflow_flag_clr <= 1'b0;
        hist_irq_flag_clr <= 1'b0;
        tick(1);
    endtask
    // verdict and end of run
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        end_of_test;
    end
    // main sequence
    initial begin
        void'($urandom(84588));
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        hist_buffer_enable <= 1'b1;
        irq_sources <= 4'($urandom);
        tick(1);
        chk("empty", 1, hist_empty_flag);
        store(0, 1);
        chk("irq", 1, hist_irq_flag);
        chk("status", {1'b1, irq_sources}, global_tx_irq_status);
        chk("txirq", 1, channel_tx_interrupt);
        clr(0);
        store(1, 0);
        @(posedge sys_clk) hist_log_kinds <= 3'b001;
        store(1, 1);
        store(2, 1);
        @(posedge sys_clk) hist_log_kinds <= 3'h7;
        for (int i = 0; i < 16; i++) store($urandom_range(2), 1);
        chk("full", 16, hist_count);
        chk("ovf", 1, hist_overflow_flag);
        chk("err", 1, global_error_irq);
        chk("fullflag", 1, hist_full_flag);
        @(posedge sys_clk) hist_overflow_irq_enable <= 1'b0;
        tick(2);
        chk("errgate", 0, global_error_irq);
        chk("ovfhold", 1, hist_overflow_flag);
        @(posedge sys_clk) hist_overflow_irq_enable <= 1'b1;
        tick(1);
        for (int i = 0; i < 17; i++) pop(8'hFF);
        chk("emptyagain", 1, hist_empty_flag);
        chk("fullgone", 0, hist_full_flag);
        clr(1);
        chk("ovfclr", 0, hist_overflow_flag);
        @(posedge sys_clk) hist_irq_mode_sel <= 1'b0;
        clr(0);
        for (int i = 1; i <= 6; i++) begin
            store(i % 3, 1);
            chk("irq6", i == 6, hist_irq_flag);
        end
        @(posedge sys_clk) hist_buffer_enable <= 1'b0;
        tick(1);
        pop(8'hFF);
        chk("irqkeep", 1, hist_irq_flag);
        @(posedge sys_clk) hist_buffer_enable <= 1'b1;
        tick(1);
        pop(8'h7F);
        // history source masked: status bit 4 and its share of the line drop
        @(posedge sys_clk) hist_irq_enable <= 1'b0;
        tick(2);
        chk("statgate", {1'b0, irq_sources}, global_tx_irq_status);
        chk("txirqgate", |irq_sources, channel_tx_interrupt);
        end_of_test;
    end
endmodule // can_tx_history_buffer_tb_top

// File: cth_history.sv
// device end: per-channel transmit history buffer with interrupts
`timescale 1ns/10ps
module cth_history #(
    parameter int DEPTH = cth_pkg::DEPTH,
    parameter int IRQ_LEVEL = cth_pkg::IRQ_LEVEL
) (
    input wire logic sys_clk,
    input wire logic rst,
    cth_if.device link,
    // configuration (hist_config_reg fields)
    input wire logic hist_buffer_enable,
    input wire logic hist_irq_mode_sel,
    input wire logic hist_irq_enable,
    input wire logic [2:0] hist_log_kinds,
    // global control
    input wire logic hist_overflow_irq_enable,
    // software flag clears and pointer control write
    input wire logic hist_irq_flag_clr,
    input wire logic hist_overflow_flag_clr,
    input wire logic hist_pointer_wr,
    input wire logic [7:0] hist_pointer_control,
    // status and access window
    output logic hist_irq_flag,
    output logic hist_overflow_flag,
    output logic hist_empty_flag,
    output logic hist_full_flag,
    output logic [4:0] hist_count,
    output cth_pkg::cth_rec_type hist_access_window,
    output logic [4:0] global_tx_irq_status,
    output logic channel_tx_interrupt,
    output logic global_error_irq
);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam int P_W = $clog2(DEPTH);

    typedef struct packed {
        cth_pkg::cth_rec_type [DEPTH-1:0] mem;
        logic [P_W-1:0] wr_ptr;
        logic [P_W-1:0] rd_ptr;
        logic [CNT_W-1:0] count;
        logic irq_flag;
        logic ovf_flag;
        logic [4:0] gstat;
        logic tx_irq;
        logic err_irq;
        cth_pkg::cth_rec_type window;
        logic empty_f;
        logic full_f;
    } cth_hist_state_type;

    cth_hist_state_type st;
    cth_hist_state_type next_st;

    // map a source kind to its one-hot type code
    function automatic logic [2:0] type_code(input cth_pkg::cth_src_type s);
        case (s)
            cth_pkg::SRC_TXBUF: type_code = cth_pkg::TYPE_TXBUF;
            cth_pkg::SRC_FIFO: type_code = cth_pkg::TYPE_FIFO;
            cth_pkg::SRC_QUEUE: type_code = cth_pkg::TYPE_QUEUE;
            default: type_code = 3'b000;
        endcase
    endfunction

    logic log_it;
    logic do_pop;
    logic do_push;
    logic full;
    logic empty;
    cth_pkg::cth_rec_type rec;

    // decide whether this completion is logged and build the record
    always_comb begin
        full = (st.count == CNT_W'(DEPTH));
        empty = (st.count == '0);
        // logged only if enabled, marked and kind selected
        log_it = link.tx_done && hist_buffer_enable && link.tx_hist_keep
            && ((type_code(link.tx_src) & hist_log_kinds) != 3'b000);
        rec.buf_type = type_code(link.tx_src);
        case (link.tx_src)
            cth_pkg::SRC_TXBUF: rec.buf_num = link.tx_buf_index;
            cth_pkg::SRC_FIFO: rec.buf_num = link.fifo_linked_txbuf_sel;
            cth_pkg::SRC_QUEUE: rec.buf_num = link.queue_txbuf_index;
            default: rec.buf_num = link.tx_buf_index;
        endcase
        rec.label = link.tx_label;
        rec.tstamp = link.tx_tstamp;
        // advance only on FF while enabled and not empty
        do_pop = hist_pointer_wr && (hist_pointer_control == cth_pkg::PTR_ADVANCE_CODE)
            && hist_buffer_enable && !empty;
        do_push = log_it && (!full || do_pop);
    end

    // next-state logic for the whole buffer
    always_comb begin
        next_st = st;
        if (do_push) begin
            next_st.mem[st.wr_ptr] = rec;
            next_st.wr_ptr = st.wr_ptr + P_W'(1);
        end
        if (do_pop) begin
            next_st.rd_ptr = st.rd_ptr + P_W'(1);
        end
        next_st.count = st.count + CNT_W'(do_push) - CNT_W'(do_pop);
        // clear first so that a same-cycle set wins; enable plays no part
        if (hist_irq_flag_clr) begin
            next_st.irq_flag = 1'b0;
        end
        if (do_push && (hist_irq_mode_sel || next_st.count == CNT_W'(IRQ_LEVEL))) begin
            next_st.irq_flag = 1'b1;
        end
        if (hist_overflow_flag_clr) begin
            next_st.ovf_flag = 1'b0;
        end
        if (log_it && full && !do_pop) begin
            next_st.ovf_flag = 1'b1;
        end
        // global status and combined transmit interrupt
        next_st.gstat = {next_st.irq_flag && hist_irq_enable, link.queue_irq,
            link.fifo_tx_irq, link.tx_abort_irq, link.tx_complete_irq};
        next_st.tx_irq = |next_st.gstat;
        next_st.err_irq = next_st.ovf_flag && hist_overflow_irq_enable;
        next_st.window = next_st.mem[next_st.rd_ptr];
        // level flags kept in flops so the outputs need no decode
        next_st.empty_f = (next_st.count == '0);
        next_st.full_f = (next_st.count == CNT_W'(DEPTH));
        if (rst) begin
            next_st = '0;
            next_st.empty_f = 1'b1; // buffer reads empty out of reset
        end
    end

    always_ff @(posedge sys_clk) begin
        st <= next_st;
    end

    // outputs come from the state flops
    assign hist_irq_flag = st.irq_flag;
    assign hist_overflow_flag = st.ovf_flag;
    assign hist_count = 5'(st.count);
    assign hist_empty_flag = st.empty_f;
    assign hist_full_flag = st.full_f;
    assign hist_access_window = st.window;
    assign global_tx_irq_status = st.gstat;
    assign channel_tx_interrupt = st.tx_irq;
    assign global_error_irq = st.err_irq;
endmodule // cth_history

// File: cth_history_asserts.sv
// concurrent checks on the history buffer and its link
`timescale 1ns/10ps
module cth_history_asserts #(
    parameter int DEPTH = 16,
    parameter int IRQ_LEVEL = 6
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic tx_done,
    input cth_pkg::cth_src_type tx_src,
    input wire logic tx_hist_keep,
    input wire logic hist_buffer_enable,
    input wire logic hist_irq_mode_sel,
    input wire logic hist_irq_enable,
    input wire logic [2:0] hist_log_kinds,
    input wire logic hist_overflow_irq_enable,
    input wire logic hist_irq_flag_clr,
    input wire logic hist_overflow_flag_clr,
    input wire logic hist_pointer_wr,
    input wire logic hist_irq_flag,
    input wire logic hist_overflow_flag,
    input wire logic hist_empty_flag,
    input wire logic [4:0] hist_count,
    input wire logic [4:0] global_tx_irq_status,
    input wire logic global_error_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // a completion that must be logged
    sequence s_store;
        tx_done && tx_hist_keep && hist_buffer_enable && hist_log_kinds[tx_src];
    endsequence
    AST_STORE_CNT: assert property (s_store ##0 (!hist_pointer_wr && hist_count < DEPTH)
        |=> hist_count == $past(hist_count) + 1) else $error("store did not count");
    AST_KEEP_OFF: assert property (tx_done && !tx_hist_keep && !hist_pointer_wr
        |=> $stable(hist_count)) else $error("unmarked message logged");
    AST_MODE_EACH: assert property (s_store ##0 (hist_irq_mode_sel && hist_count < DEPTH)
        |=> hist_irq_flag) else $error("no flag on store");
    AST_MODE_LEVEL: assert property (s_store ##0 (!hist_irq_mode_sel && !hist_pointer_wr
        && hist_count == IRQ_LEVEL - 1) |=> hist_irq_flag) else $error("no flag at level");
    AST_IRQ_GATE: assert property (!$past(hist_irq_enable) |-> !global_tx_irq_status[4])
        else $error("history irq not gated");
    AST_IRQ_HOLD: assert property (hist_irq_flag && !hist_irq_flag_clr |=> hist_irq_flag)
        else $error("irq flag dropped");
    AST_OVF_HOLD: assert property (hist_overflow_flag && !hist_overflow_flag_clr
        |=> hist_overflow_flag) else $error("overflow flag dropped");
    AST_OVF_SET: assert property (s_store ##0 (hist_count == DEPTH && !hist_pointer_wr)
        |=> hist_overflow_flag && hist_count == DEPTH) else $error("overflow missed");
    AST_ERR_GATE: assert property (!$past(hist_overflow_irq_enable) |-> !global_error_irq)
        else $error("error irq not gated");
    AST_POP_EMPTY: assert property (hist_pointer_wr && hist_empty_flag && !tx_done
        |=> hist_count == 0) else $error("pop on empty moved count");
endmodule // cth_history_asserts

// File: cth_if.sv
// interface joining channel transmit logic to the history buffer
`timescale 1ns/10ps
interface cth_if;
    // transmission-complete event from the channel transmit logic
    logic tx_done;
    cth_pkg::cth_src_type tx_src;
    logic [cth_pkg::BUFNUM_W-1:0] tx_buf_index;
    logic [cth_pkg::BUFNUM_W-1:0] fifo_linked_txbuf_sel;
    logic [cth_pkg::BUFNUM_W-1:0] queue_txbuf_index;
    logic tx_hist_keep;
    logic [cth_pkg::LABEL_W-1:0] tx_label;
    logic [cth_pkg::TSTAMP_W-1:0] tx_tstamp;
    // other transmit interrupt sources, combined by the history block
    logic tx_complete_irq;
    logic tx_abort_irq;
    logic fifo_tx_irq;
    logic queue_irq;
    modport device (
        input tx_done, tx_src, tx_buf_index, fifo_linked_txbuf_sel,
        input queue_txbuf_index, tx_hist_keep, tx_label, tx_tstamp,
        input tx_complete_irq, tx_abort_irq, fifo_tx_irq, queue_irq
    );
    modport host (
        output tx_done, tx_src, tx_buf_index, fifo_linked_txbuf_sel,
        output queue_txbuf_index, tx_hist_keep, tx_label, tx_tstamp,
        output tx_complete_irq, tx_abort_irq, fifo_tx_irq, queue_irq
    );
endinterface

// File: cth_pkg.sv
// package of constants and types for the transmit history buffer
package cth_pkg;
    localparam int DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int BUFNUM_W = 4;
    localparam int LABEL_W = 16;
    localparam int TSTAMP_W = 16;
    localparam int IRQ_LEVEL = 6;
    localparam logic [7:0] PTR_ADVANCE_CODE = 8'hFF;
    localparam logic [2:0] TYPE_TXBUF = 3'b001;
    localparam logic [2:0] TYPE_FIFO = 3'b010;
    localparam logic [2:0] TYPE_QUEUE = 3'b100;
    localparam logic [4:0] PTR_RESET = 5'h0;
    // source kind of a completed transmission
    typedef enum logic [1:0] {
        SRC_TXBUF = 2'b00,
        SRC_FIFO = 2'b01,
        SRC_QUEUE = 2'b10
    } cth_src_type;
    // one stored record
    typedef struct packed {
        logic [2:0] buf_type;
        logic [BUFNUM_W-1:0] buf_num;
        logic [LABEL_W-1:0] label;
        logic [TSTAMP_W-1:0] tstamp;
    } cth_rec_type;
endpackage

// File: cth_tx_source.sv
// channel transmit logic end: issues completion events into the history buffer
`timescale 1ns/10ps
module cth_tx_source (
    input wire logic sys_clk,
    input wire logic rst,
    cth_if.host link,
    input wire logic done_req,
    input wire logic [1:0] done_src,
    input wire logic [cth_pkg::BUFNUM_W-1:0] done_buf_index,
    input wire logic [cth_pkg::BUFNUM_W-1:0] done_fifo_link,
    input wire logic [cth_pkg::BUFNUM_W-1:0] done_queue_index,
    input wire logic done_keep,
    input wire logic [cth_pkg::LABEL_W-1:0] done_label,
    input wire logic [cth_pkg::TSTAMP_W-1:0] done_tstamp,
    input wire logic [3:0] irq_sources
);
    typedef struct packed {
        logic tx_done;
        logic [1:0] src;
        logic [cth_pkg::BUFNUM_W-1:0] buf_index;
        logic [cth_pkg::BUFNUM_W-1:0] fifo_link;
        logic [cth_pkg::BUFNUM_W-1:0] queue_index;
        logic keep;
        logic [cth_pkg::LABEL_W-1:0] label;
        logic [cth_pkg::TSTAMP_W-1:0] tstamp;
        logic [3:0] irqs;
    } cth_src_state_type;

    cth_src_state_type st;
    cth_src_state_type next_st;

    // register each completion event for one cycle and hold its record fields until the next one
    always_comb begin
        next_st = st;
        next_st.tx_done = done_req;
        next_st.keep = done_keep;
        next_st.irqs = irq_sources;
        if (done_req) begin
            next_st.src = done_src;
            next_st.buf_index = done_buf_index;
            next_st.fifo_link = done_fifo_link;
            next_st.queue_index = done_queue_index;
            next_st.label = done_label;
            next_st.tstamp = done_tstamp;
        end
        if (rst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        st <= next_st;
    end

    // drive the link from state flops
    assign link.tx_done = st.tx_done;
    assign link.tx_src = cth_pkg::cth_src_type'(st.src);
    assign link.tx_buf_index = st.buf_index;
    assign link.fifo_linked_txbuf_sel = st.fifo_link;
    assign link.queue_txbuf_index = st.queue_index;
    assign link.tx_hist_keep = st.keep;
    assign link.tx_label = st.label;
    assign link.tx_tstamp = st.tstamp;
    assign link.tx_complete_irq = st.irqs[0];
    assign link.tx_abort_irq = st.irqs[1];
    assign link.fifo_tx_irq = st.irqs[2];
    assign link.queue_irq = st.irqs[3];
endmodule // cth_tx_source
